// File: src/icf_pkg.sv
// How it works
// R1: Channel report message starts 0x60, 0x12, then instance, call type, channel.
// R2: Call type codes: 0 mu-law, 1 A-law, 2 data 64k, 3 data 56k.
// R3: Channel report answering an outgoing request carries call type 0xFF.
// R4: Bearer channel byte is 0x00 for first B channel, 0x01 for second.
// R5: Call instance byte is 0x00 for first instance, 0x01 for second.
// R6: Call proceeding report is 0x60, 0x13, instance, then don't-care bytes.
// R7: Alerting report is 0x60, 0x14, instance, then don't-care bytes.
// R8: Connect report is 0x60, 0x15, instance, then don't-care bytes.
// R9: Status message: 0x60, 0x22, switch type, two call states, major, minor.
// R10: Status message answers every switch-kind request and every status query; the code sends one message for requests that arrive while one is pending.
// R11: Error message is 0x99 then error type code, rest don't-care.
// R12: Internal fault codes 0, 2, 5, 9 and 11.
// R13: Transceiver fault codes 6 underrun, 7 frame overflow, 10 data overflow.
// R14: Host resets the device after an error message.
// R15: Clearing cause byte carries the network cause code as given.
// R16: Host ignores don't-care bytes; device fills them freely.
// R17: Cause with upper nibble zero means internal error, otherwise switch error.
// R18: Byte shown with available line low; host pulses ack high-low-high.
// R19: Every message is exactly ten bytes, one handshake per byte.
// R20: One message finishes before the next one starts.
package icf_pkg;
  localparam int MSG_LEN = 10;
  localparam logic [3:0] LAST_IDX = 4'h9;
  localparam logic [7:0] HDR_CALL = 8'h60;
  localparam logic [7:0] HDR_ERROR = 8'h99;
  localparam logic [7:0] OP_CHANNEL = 8'h12;
  localparam logic [7:0] OP_PROCEED = 8'h13;
  localparam logic [7:0] OP_ALERT = 8'h14;
  localparam logic [7:0] OP_CONNECT = 8'h15;
  localparam logic [7:0] OP_CLEAR = 8'h11;
  localparam logic [7:0] OP_STATUS = 8'h22;
  localparam logic [7:0] CTYPE_ULAW = 8'h00;
  localparam logic [7:0] CTYPE_ALAW = 8'h01;
  localparam logic [7:0] CTYPE_D64 = 8'h02;
  localparam logic [7:0] CTYPE_D56 = 8'h03;
  localparam logic [7:0] CTYPE_NONE = 8'hFF;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [7:0] ERR_TASKQ = 8'h00;
  localparam logic [7:0] ERR_MEM = 8'h02;
  localparam logic [7:0] ERR_L3Q = 8'h05;
  localparam logic [7:0] ERR_TX_UNDER = 8'h06;
  localparam logic [7:0] ERR_RX_FRAME = 8'h07;
  localparam logic [7:0] ERR_OUTQ = 8'h09;
  localparam logic [7:0] ERR_RX_DATA = 8'h0A;
  localparam logic [7:0] ERR_BUS = 8'h0B;
  // Message kinds in request priority order
  typedef enum logic [2:0] {
    KIND_ERROR, KIND_STATUS, KIND_CHANNEL, KIND_CLEAR,
    KIND_PROCEED, KIND_ALERT, KIND_CONNECT
  } icf_kind_type;
endpackage

// File: src/icf_byte_buf.sv
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer, full throughput, registered outputs
module icf_byte_buf (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  input wire logic [7:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [7:0] outData,
  input wire logic outReady
);
  logic [7:0] mem_r [0:1];
  logic [7:0] mem_nxt [0:1];
  logic wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [1:0] count_r, count_nxt;
  logic push, pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign inReady = (count_r != 2'd2);
  assign outValid = (count_r != 2'd0);
  assign outData = mem_r[rdPtr_r];

  always_comb begin
    mem_nxt[0] = mem_r[0];
    mem_nxt[1] = mem_r[1];
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt = ~wrPtr_r;
    end
    if (pop) begin
      rdPtr_nxt = ~rdPtr_r;
    end
    if (push && !pop) begin
      count_nxt = count_r + 2'd1;
    end else if (pop && !push) begin
      count_nxt = count_r - 2'd1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'd0;
    end else begin
      mem_r[0] <= mem_nxt[0];
      mem_r[1] <= mem_nxt[1];
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule // icf_byte_buf
`default_nettype wire

// File: src/icf_framer.sv
`timescale 1ns/100ps
`default_nettype none
module icf_framer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Channel report
  input wire logic channelReq,
  input wire logic channelOutgoing,
  input wire logic channelInstance,
  input wire logic channelBearer,
  input wire logic [1:0] channelCallType,
  // Call progress reports
  input wire logic proceedingReq,
  input wire logic alertingReq,
  input wire logic connectReq,
  input wire logic progressInstance,
  // Clearing report
  input wire logic clearReq,
  input wire logic clearInstance,
  input wire logic [7:0] clearCause,
  // Status report, on switch-kind request or status query
  input wire logic switchKindRequest,
  input wire logic statusQueryRequest,
  input wire logic [7:0] switchKind,
  input wire logic [7:0] callState1,
  input wire logic [7:0] callState2,
  input wire logic [7:0] releaseMajor,
  input wire logic [7:0] releaseMinor,
  // Fault events
  input wire logic taskQueueOverflow,
  input wire logic memoryUnderrun,
  input wire logic l3QueueOverflow,
  input wire logic outQueueOverflow,
  input wire logic chipBusFatal,
  input wire logic txUnderrunFlag,
  input wire logic rxFrameOverflowFlag,
  input wire logic rxDataOverflowFlag,
  // Host byte port
  output logic [7:0] hostData,
  output logic byteAvailableLine_n,
  input wire logic byteAckLine,
  // Status
  output logic busy,
  output logic errorHalted,
  output logic clearInternal
);
  import icf_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_HALT} icf_state_type;
  typedef enum logic [1:0] {HS_IDLE, HS_SHOW, HS_ACKLOW} icf_hs_type;

  // Pending request flags; a new event wins over the take in the same cycle
  logic [6:0] pend_r, pend_nxt, evt;
  logic errPend_r, errPend_nxt;
  logic [7:0] errCode_r, errCode_nxt, errSel;
  icf_state_type state_r, state_nxt;
  icf_kind_type kind_r, kind_nxt, pick;
  logic [3:0] idx_r, idx_nxt;
  logic [7:0] msg_r [0:MSG_LEN-1];
  logic [7:0] msg_nxt [0:MSG_LEN-1];
  logic anyPend;
  // Buffer link
  logic bufInValid, bufInReady, bufOutValid, bufOutReady;
  logic [7:0] bufOutData;
  // Host handshake
  icf_hs_type hs_r, hs_nxt;
  logic [7:0] hostData_r, hostData_nxt;
  logic avail_n_r, avail_n_nxt;
  logic busy_r, busy_nxt, halted_r, halted_nxt, clrInt_r, clrInt_nxt;

  // Highest-priority internal fault first; transceiver faults after
  function automatic logic [7:0] err_code(input logic [7:0] f);
    err_code = ERR_TASKQ;
    if (f[0]) err_code = ERR_TASKQ; // see R12
    else if (f[1]) err_code = ERR_MEM;
    else if (f[2]) err_code = ERR_L3Q;
    else if (f[3]) err_code = ERR_OUTQ;
    else if (f[4]) err_code = ERR_BUS;
    else if (f[5]) err_code = ERR_TX_UNDER; // see R13
    else if (f[6]) err_code = ERR_RX_FRAME;
    else if (f[7]) err_code = ERR_RX_DATA;
  endfunction

  // Instance and channel numbers travel as a whole byte
  function automatic logic [7:0] inst_byte(input logic b);
    inst_byte = {7'd0, b};
  endfunction

  logic [7:0] faults;
  assign faults = {rxDataOverflowFlag, rxFrameOverflowFlag, txUnderrunFlag, chipBusFatal,
                   outQueueOverflow, l3QueueOverflow, memoryUnderrun, taskQueueOverflow};
  assign errSel = err_code(faults);
  // Both status triggers share one pending bit, so two close together merge
  assign evt = {connectReq, alertingReq, proceedingReq, clearReq, channelReq,
                switchKindRequest || statusQueryRequest, 1'b0}; // see R10
  assign anyPend = errPend_r || (pend_r[6:1] != 6'd0);

  always_comb begin
    pick = KIND_STATUS;
    if (errPend_r) pick = KIND_ERROR;
    else if (pend_r[1]) pick = KIND_STATUS;
    else if (pend_r[2]) pick = KIND_CHANNEL;
    else if (pend_r[3]) pick = KIND_CLEAR;
    else if (pend_r[4]) pick = KIND_PROCEED;
    else if (pend_r[5]) pick = KIND_ALERT;
    else if (pend_r[6]) pick = KIND_CONNECT;
  end

  // Message assembly and byte sequencing
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    idx_nxt = idx_r;
    pend_nxt = pend_r;
    errPend_nxt = errPend_r;
    errCode_nxt = errCode_r;
    for (int i = 0; i < MSG_LEN; i++) begin
      msg_nxt[i] = msg_r[i];
    end
    bufInValid = 1'b0;
    // Only the first fault is kept; later ones are moot until reset
    if ((faults != 8'h00) && !errPend_r && (state_r != ST_HALT)) begin
      errPend_nxt = 1'b1;
      errCode_nxt = errSel;
    end
    case (state_r)
      ST_IDLE: begin
        if (anyPend) begin
          kind_nxt = pick;
          idx_nxt = 4'h0;
          state_nxt = ST_SEND;
          for (int i = 0; i < MSG_LEN; i++) begin
            msg_nxt[i] = FILL_BYTE; // see R16
          end
          msg_nxt[0] = HDR_CALL;
          case (pick)
            KIND_ERROR: begin
              msg_nxt[0] = HDR_ERROR; // see R11
              msg_nxt[1] = errCode_r;
              errPend_nxt = 1'b0;
            end
            KIND_STATUS: begin
              msg_nxt[1] = OP_STATUS; // see R9
              msg_nxt[2] = switchKind;
              msg_nxt[3] = callState1;
              msg_nxt[4] = callState2;
              msg_nxt[5] = releaseMajor;
              msg_nxt[6] = releaseMinor;
            end
            KIND_CHANNEL: begin
              msg_nxt[1] = OP_CHANNEL; // see R1
              msg_nxt[2] = inst_byte(channelInstance); // see R5
              msg_nxt[3] = channelOutgoing ? CTYPE_NONE : {6'd0, channelCallType}; // see R2 see R3
              msg_nxt[4] = inst_byte(channelBearer); // see R4
            end
            KIND_CLEAR: begin
              msg_nxt[1] = OP_CLEAR;
              msg_nxt[2] = inst_byte(clearInstance);
              msg_nxt[3] = clearCause; // see R15
            end
            KIND_PROCEED: begin
              msg_nxt[1] = OP_PROCEED; // see R6
              msg_nxt[2] = inst_byte(progressInstance);
            end
            KIND_ALERT: begin
              msg_nxt[1] = OP_ALERT; // see R7
              msg_nxt[2] = inst_byte(progressInstance);
            end
            KIND_CONNECT: begin
              msg_nxt[1] = OP_CONNECT; // see R8
              msg_nxt[2] = inst_byte(progressInstance);
            end
            default: begin
              msg_nxt[1] = FILL_BYTE;
            end
          endcase
          if (pick != KIND_ERROR) begin
            pend_nxt[pick] = 1'b0;
          end
        end
      end
      ST_SEND: begin
        bufInValid = 1'b1;
        if (bufInReady) begin
          if (idx_r == LAST_IDX) begin // see R19
            // After an error report nothing more goes out until reset
            state_nxt = (kind_r == KIND_ERROR) ? ST_HALT : ST_IDLE; // see R20
          end else begin
            idx_nxt = idx_r + 4'h1;
          end
        end
      end
      ST_HALT: begin
        state_nxt = ST_HALT;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    pend_nxt = pend_nxt | evt;
  end

  icf_byte_buf icf_byte_buf_inst (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(bufInValid),
    .inData(msg_r[idx_r]),
    .inReady(bufInReady),
    .outValid(bufOutValid),
    .outData(bufOutData),
    .outReady(bufOutReady)
  );

  // Host side: line low while a byte stands, released after ack rises again
  assign bufOutReady = (hs_r == HS_IDLE);
  always_comb begin
    hs_nxt = hs_r;
    hostData_nxt = hostData_r;
    avail_n_nxt = avail_n_r;
    case (hs_r)
      HS_IDLE: begin
        if (bufOutValid) begin
          hostData_nxt = bufOutData;
          avail_n_nxt = 1'b0; // see R18
          hs_nxt = HS_SHOW;
        end
      end
      HS_SHOW: begin
        if (!byteAckLine) hs_nxt = HS_ACKLOW;
      end
      HS_ACKLOW: begin
        if (byteAckLine) begin
          avail_n_nxt = 1'b1; // see R18
          hs_nxt = HS_IDLE;
        end
      end
      default: begin
        hs_nxt = HS_IDLE;
      end
    endcase
  end

  // Status outputs, registered so that every top output leaves a flip-flop
  always_comb begin
    busy_nxt = (state_nxt == ST_SEND) || (hs_nxt != HS_IDLE) || bufOutValid;
    halted_nxt = (state_nxt == ST_HALT);
    clrInt_nxt = (clearCause[7:4] == 4'h0); // see R17
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      kind_r <= KIND_STATUS;
      idx_r <= 4'h0;
      pend_r <= 7'd0;
      errPend_r <= 1'b0;
      errCode_r <= 8'h00;
      for (int i = 0; i < MSG_LEN; i++) begin
        msg_r[i] <= 8'h00;
      end
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      idx_r <= idx_nxt;
      pend_r <= pend_nxt;
      errPend_r <= errPend_nxt;
      errCode_r <= errCode_nxt;
      for (int i = 0; i < MSG_LEN; i++) begin
        msg_r[i] <= msg_nxt[i];
      end
    end
  end

  // A host that never acks stalls the sequencer; requests keep pending meanwhile
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hs_r <= HS_IDLE;
      hostData_r <= 8'h00;
      avail_n_r <= 1'b1;
    end else begin
      hs_r <= hs_nxt;
      hostData_r <= hostData_nxt;
      avail_n_r <= avail_n_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      halted_r <= 1'b0;
      clrInt_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      halted_r <= halted_nxt;
      clrInt_r <= clrInt_nxt;
    end
  end

  assign hostData = hostData_r;
  assign byteAvailableLine_n = avail_n_r;
  assign busy = busy_r;
  assign errorHalted = halted_r;
  assign clearInternal = clrInt_r;
endmodule // icf_framer
`default_nettype wire

// File: dv/icf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module icf_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Byte port
  input wire logic [7:0] hostData,
  input wire logic byteAvailableLine_n,
  output logic byteAckLine,
  // Pace of the host, in cycles before acking
  input wire logic [3:0] ackDelay
);
  logic [7:0] rxQ[$];
  initial begin
    byteAckLine = 1'b1;
    // Sampled and driven at the falling edge, clear of the launch edge
    forever begin
      @(negedge core_clk);
      if (!rst && byteAvailableLine_n === 1'b0) begin
        rxQ.push_back(hostData);
        repeat (ackDelay) @(negedge core_clk);
        byteAckLine = 1'b0;
        @(negedge core_clk);
        byteAckLine = 1'b1;
        // Never take the same byte twice
        while (byteAvailableLine_n !== 1'b1) @(negedge core_clk);
      end
    end
  end
endmodule // icf_host_model
`default_nettype wire

// File: dv/icf_framer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module icf_framer_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire logic [7:0] clearCause,
  input wire logic [7:0] hostData,
  input wire logic byteAvailableLine_n,
  input wire logic byteAckLine,
  input wire logic busy,
  input wire logic errorHalted,
  input wire logic clearInternal
);
  logic [3:0] byteIdx_r;
  logic ackSeen_r;
  logic [7:0] head_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Position of the presented byte within its message
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byteIdx_r <= 4'h0;
      ackSeen_r <= 1'b0;
      head_r <= 8'h00;
    end else begin
      ackSeen_r <= !byteAvailableLine_n && (ackSeen_r || !byteAckLine);
      if ($fell(byteAvailableLine_n)) begin
        byteIdx_r <= (byteIdx_r == 4'h9) ? 4'h0 : byteIdx_r + 4'h1;
        if (byteIdx_r == 4'h0) head_r <= hostData;
      end
    end
  end
  AST_DATA_HOLD: assert property (!byteAvailableLine_n && $past(!byteAvailableLine_n)
    |-> $stable(hostData)) else $error("byte changed while presented");
  AST_RISE_AFTER_ACK: assert property ($rose(byteAvailableLine_n) |-> ackSeen_r)
    else $error("byte withdrawn without ack");
  AST_RELEASE_TIME: assert property (!byteAvailableLine_n && $rose(byteAckLine)
    |=> byteAvailableLine_n) else $error("available line not released");
  AST_HEADER: assert property ($fell(byteAvailableLine_n) && byteIdx_r == 4'h0
    |-> hostData inside {8'h60, 8'h99}) else $error("bad first byte");
  AST_OPCODE: assert property ($fell(byteAvailableLine_n) && byteIdx_r == 4'h1
    |-> (head_r == 8'h60 && hostData inside {[8'h11:8'h15], 8'h22})
    || (head_r == 8'h99 && hostData inside {8'h00, 8'h02, [8'h05:8'h07], [8'h09:8'h0B]}))
    else $error("bad second byte");
  AST_BUSY_MID: assert property (byteIdx_r != 4'h0 |-> busy)
    else $error("idle in mid message");
  AST_HALT_STICKY: assert property (errorHalted |=> errorHalted)
    else $error("halt dropped without reset");
  AST_HALT_QUIET: assert property (errorHalted && byteIdx_r == 4'h0 && byteAvailableLine_n
    |=> byteAvailableLine_n [*8]) else $error("byte sent after error message");
  AST_CAUSE_CLASS: assert property (!$past(rst)
    |-> clearInternal == ($past(clearCause[7:4]) == 4'h0)) else $error("cause class wrong");
endmodule // icf_framer_sva
bind icf_framer icf_framer_sva icf_framer_sva_inst (.core_clk, .rst, .clearCause, .hostData,
  .byteAvailableLine_n, .byteAckLine, .busy, .errorHalted, .clearInternal);
`default_nettype wire

// File: dv/isdn_call_indication_framer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module isdn_call_indication_framer_bench;
  logic core_clk, rst, channelReq, channelOutgoing, channelInstance, channelBearer;
  logic [1:0] channelCallType;
  logic proceedingReq, alertingReq, connectReq, progressInstance, clearReq, clearInstance;
  logic [7:0] clearCause, switchKind, callState1, callState2, releaseMajor, releaseMinor;
  logic taskQueueOverflow, memoryUnderrun, l3QueueOverflow, outQueueOverflow, chipBusFatal;
  logic txUnderrunFlag, rxFrameOverflowFlag, rxDataOverflowFlag;
  logic switchKindRequest, statusQueryRequest;
  logic [7:0] hostData;
  logic byteAvailableLine_n, byteAckLine, busy, errorHalted, clearInternal;
  logic [3:0] ackDelay;
  int numErrors = 0;
  int checks = 0;
  icf_framer icf_framer_inst (.core_clk, .rst, .channelReq, .channelOutgoing, .channelInstance,
    .channelBearer, .channelCallType, .proceedingReq, .alertingReq, .connectReq, .progressInstance,
    .clearReq, .clearInstance, .clearCause, .switchKindRequest, .statusQueryRequest, .switchKind,
    .callState1, .callState2, .releaseMajor, .releaseMinor, .taskQueueOverflow, .memoryUnderrun,
    .l3QueueOverflow, .outQueueOverflow, .chipBusFatal, .txUnderrunFlag, .rxFrameOverflowFlag,
    .rxDataOverflowFlag, .hostData, .byteAvailableLine_n, .byteAckLine, .busy, .errorHalted,
    .clearInternal);
  icf_host_model icf_host_model_inst (.core_clk, .rst, .hostData, .byteAvailableLine_n,
    .byteAckLine, .ackDelay);
  always #2 core_clk = ~core_clk;
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic set_faults(input logic [7:0] f);
    {taskQueueOverflow, memoryUnderrun, l3QueueOverflow, outQueueOverflow, chipBusFatal,
      txUnderrunFlag, rxFrameOverflowFlag, rxDataOverflowFlag} = f;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    icf_host_model_inst.rxQ.delete();
  endtask
  // Only the first n bytes are defined; the rest are left unjudged
  task automatic expect_msg(input logic [55:0] exp, input int n);
    int i;
    i = 0;
    while (icf_host_model_inst.rxQ.size() < 10 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    check("msgLen", 8'(icf_host_model_inst.rxQ.size()), 8'h0A);
    for (i = 0; i < n; i++) check("msgByte", icf_host_model_inst.rxQ[i], exp[55-8*i -: 8]);
    repeat (10) if (icf_host_model_inst.rxQ.size() > 0) void'(icf_host_model_inst.rxQ.pop_front());
  endtask
  task automatic test_channel();
    for (int k = 0; k < 5; k++) begin
      channelOutgoing = (k == 4);
      channelInstance = k[0];
      channelBearer = k[1];
      channelCallType = k[1:0];
      pulse(channelReq);
      expect_msg({8'h60, 8'h12, 7'h0, k[0], (k == 4) ? 8'hFF : {6'h0, k[1:0]},
        7'h0, k[1], 16'h0000}, 5);
    end
  endtask
  // Three reports at once to a slow host: whole messages, in priority order
  task automatic test_progress();
    ackDelay = 4'hC;
    progressInstance = 1'b1;
    @(negedge core_clk);
    {proceedingReq, alertingReq, connectReq} = 3'b111;
    @(negedge core_clk);
    {proceedingReq, alertingReq, connectReq} = 3'b000;
    for (int k = 0; k < 3; k++) expect_msg({8'h60, 8'h13 + 8'(k), 8'h01, 32'h0}, 3);
    ackDelay = 4'h0;
    progressInstance = 1'b0;
    pulse(connectReq);
    expect_msg({8'h60, 8'h15, 8'h00, 32'h0}, 3);
  endtask
  task automatic test_status();
    {switchKind, callState1, callState2, releaseMajor, releaseMinor} = 40'h03_0A13_0207;
    pulse(switchKindRequest);
    expect_msg({8'h60, 8'h22, 40'h03_0A13_0207}, 7);
    pulse(statusQueryRequest);
    expect_msg({8'h60, 8'h22, 40'h03_0A13_0207}, 7);
  endtask
  task automatic test_clear();
    logic [7:0] causes [4] = '{8'h05, 8'hD1, 8'hE6, 8'hFF};
    foreach (causes[k]) begin
      clearCause = causes[k];
      clearInstance = k[0];
      repeat (2) @(negedge core_clk);
      check("clearInternal", 8'(clearInternal), 8'(causes[k][7:4] == 4'h0));
      pulse(clearReq);
      expect_msg({8'h60, 8'h11, 7'h0, k[0], causes[k], 24'h0}, 4);
    end
  endtask
  // Last case raises two faults together; the higher one is reported
  task automatic test_errors();
    logic [7:0] codes [9] = '{8'h00, 8'h02, 8'h05, 8'h09, 8'h0B, 8'h06, 8'h07, 8'h0A, 8'h00};
    for (int k = 0; k < 9; k++) begin
      do_reset();
      check("haltCleared", 8'(errorHalted), 8'h00);
      set_faults((k == 8) ? 8'h81 : 8'h80 >> k);
      @(negedge core_clk);
      set_faults(8'h00);
      expect_msg({8'h99, codes[k], 40'h0}, 2);
      check("errorHalted", 8'(errorHalted), 8'h01);
      pulse(channelReq);
      repeat (40) @(negedge core_clk);
      check("refused", 8'(icf_host_model_inst.rxQ.size()), 8'h00);
      check("busyHalted", 8'(busy), 8'h00);
    end
    do_reset();
  endtask
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ackDelay = 4'h0;
    {channelReq, channelOutgoing, channelInstance, channelBearer, channelCallType} = '0;
    {proceedingReq, alertingReq, connectReq, progressInstance, clearReq, clearInstance} = '0;
    {clearCause, switchKind, callState1, callState2, releaseMajor, releaseMinor} = '0;
    {switchKindRequest, statusQueryRequest} = 2'b00;
    set_faults(8'h00);
    do_reset();
    test_channel();
    test_progress();
    test_status();
    test_clear();
    test_errors();
    finish_test();
  end
  initial begin
    #160000;
    numErrors++;
    finish_test();
  end
endmodule // isdn_call_indication_framer_bench
`default_nettype wire
